/* verilog/fci_host_ctrl.sv */
// Operation
// - Release frame is opcode ABh alone; new work waits out the release time.
// - Select stays high through the whole release wait.
// - Device ID read is ABh, three dummy bytes, then ID bytes MSB first.
// - Signature form waits the longer signature release time before new work.
// - Opcode 90h sends address zero, then reads manufacturer and device bytes.
// - Opcode 92h sends address and reads data two bits per clock.
// - Dual ID read sends continuous read mode byte as FFh.
// - Opcode 94h sends address and reads data four bits per clock.
// - Quad ID read sends continuous read mode byte as FFh.
// - Opcode 4Bh, four dummy bytes, then the 64-bit unique number.
// - Opcode 9Fh, no address, reads manufacturer, memory type, capacity bytes.
// - Opcode 5Ah, address, eight dummy clocks; data after the fortieth clock.
// - Parameter table address has upper sixteen bits zero, low byte is start.
`timescale 1ns/10ps
`default_nettype none
module fci_host_ctrl #(
  parameter int unsigned SCLK_HALF_DIV        = fci_pkg::SCLK_HALF_DIV,
  parameter logic [15:0] RELEASE_WAIT_CYC     = fci_pkg::RELEASE_WAIT_CYC,
  parameter logic [15:0] SIG_RELEASE_WAIT_CYC = fci_pkg::SIG_RELEASE_WAIT_CYC
) (
  input  wire logic             ref_clk_i,    // System clock, 25 MHz
  input  wire logic             srst_i,       // Sync reset, active high
  input  wire logic             cmd_valid_i,  // Command request
  output logic                  cmd_ready_o,  // Ready for a command
  input  wire fci_pkg::fci_cmd_s cmd_i,       // Command kind and arguments
  output var fci_pkg::fci_rx_s  rx_o,         // Received byte and strobe
  output logic                  done_o,       // Command finished pulse
  output var fci_pkg::fci_spi_s spi_o,        // Serial clock, select, io drive
  input  wire logic [3:0]       io_i          // Sampled io lines
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fci_pkg::fci_state_e state;
  fci_pkg::fci_seg_e   seg;
  fci_pkg::fci_cmd_s   cmd_q;
  logic [31:0]         tx_sr;
  logic [7:0]          rx_sr;
  logic [3:0]          rx_bits;
  logic [15:0]         clk_left;
  logic                sclk;
  logic                cs_n;
  logic [3:0]          io_o_q;
  logic [3:0]          io_oe_q;
  logic [7:0]          rx_data;
  logic                rx_valid;
  logic                done;
  logic                tick;
  logic                timer_done;
  logic                timer_busy;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire        is_rel   = cmd_q.kind == fci_pkg::FCI_CMD_RELEASE;
  wire        is_devid = cmd_q.kind == fci_pkg::FCI_CMD_DEVICE_ID;
  wire        is_mfr   = cmd_q.kind == fci_pkg::FCI_CMD_MFR_ID;
  wire        is_dual  = cmd_q.kind == fci_pkg::FCI_CMD_MFR_ID_DUAL;
  wire        is_quad  = cmd_q.kind == fci_pkg::FCI_CMD_MFR_ID_QUAD;
  wire        is_uid   = cmd_q.kind == fci_pkg::FCI_CMD_UNIQUE_ID;
  wire        is_jedec = cmd_q.kind == fci_pkg::FCI_CMD_JEDEC_ID;
  wire        is_param = cmd_q.kind == fci_pkg::FCI_CMD_PARAM_TABLE;
  wire [1:0]  lane_sh  = is_quad ? 2'h2 : (is_dual ? 2'h1 : 2'h0);
  wire        has_addr = is_mfr | is_dual | is_quad | is_param;
  wire        has_mode = is_dual | is_quad;
  wire        need_wait = is_rel | is_devid;
  wire [15:0] wait_len = is_rel ? RELEASE_WAIT_CYC : SIG_RELEASE_WAIT_CYC;

  // Dummy clocks per kind
  wire [15:0] dummy_clks = is_devid ? fci_pkg::DEV_ID_DUMMY :
                           is_uid   ? fci_pkg::UID_DUMMY :
                           is_param ? fci_pkg::PARAM_DUMMY :
                           is_quad  ? fci_pkg::QUAD_ID_DUMMY : 16'h0000;

  // Read length in clocks; a plain release reads nothing
  wire [15:0] read_clks = is_rel ? 16'h0000 :
                          ({5'h00, cmd_q.read_bytes, 3'h0} >> lane_sh);

  // Address word: zero for ID reads, start byte for the table
  wire [23:0] addr_word = is_param ? {fci_pkg::PARAM_ADDR_HI, cmd_q.start_byte}
                                   : fci_pkg::ID_ADDR;

  // ----------------------------------------------------------------
  // Segment sequencing
  // ----------------------------------------------------------------
  wire fci_pkg::fci_seg_e seg_to_read  = (read_clks != 16'h0000) ? fci_pkg::SEG_READ
                                                                 : fci_pkg::SEG_END;
  wire fci_pkg::fci_seg_e seg_to_dummy = (dummy_clks != 16'h0000) ? fci_pkg::SEG_DUMMY
                                                                  : seg_to_read;
  wire fci_pkg::fci_seg_e seg_to_mode  = has_mode ? fci_pkg::SEG_MODE : seg_to_dummy;
  wire fci_pkg::fci_seg_e next_seg =
    (seg == fci_pkg::SEG_OP)   ? (has_addr ? fci_pkg::SEG_ADDR : seg_to_dummy) :
    (seg == fci_pkg::SEG_ADDR) ? seg_to_mode :
    (seg == fci_pkg::SEG_MODE) ? seg_to_dummy :
    (seg == fci_pkg::SEG_DUMMY) ? seg_to_read : fci_pkg::SEG_END;

  // Clock count and shift load for the next segment
  wire [15:0] next_clks =
    (next_seg == fci_pkg::SEG_ADDR)  ? (fci_pkg::ADDR_BITS >> lane_sh) :
    (next_seg == fci_pkg::SEG_MODE)  ? (fci_pkg::MODE_BITS >> lane_sh) :
    (next_seg == fci_pkg::SEG_DUMMY) ? dummy_clks :
    (next_seg == fci_pkg::SEG_READ)  ? read_clks : 16'h0000;
  wire [31:0] next_tx =
    (next_seg == fci_pkg::SEG_ADDR) ? {addr_word, 8'h00} :
    (next_seg == fci_pkg::SEG_MODE) ? {fci_pkg::MODE_BYTE_CONT, 24'h000000} :
                                      32'h00000000;

  // Lanes in use now: opcode is always one lane
  wire [1:0]  lane_cur  = (seg == fci_pkg::SEG_OP) ? 2'h0 : lane_sh;
  wire [1:0]  pin_lane  = (state == fci_pkg::ST_SHIFT) ? lane_cur : 2'h0;
  wire [3:0]  lane_n    = 4'h1 << lane_cur;
  wire [31:0] tx_shift  = tx_sr << lane_n;
  wire        rise      = (state == fci_pkg::ST_SHIFT) && tick && !sclk;
  wire        fall      = (state == fci_pkg::ST_SHIFT) && tick && sclk;
  wire        seg_last  = (clk_left == 16'h0001);
  wire        drive     = (seg == fci_pkg::SEG_OP) || (seg == fci_pkg::SEG_ADDR) ||
                          (seg == fci_pkg::SEG_MODE);

  // Pin drive: io2/io3 held high outside quad, wide lanes released to read
  wire [3:0] next_io =
    (pin_lane == 2'h2) ? tx_sr[31:28] :
    (pin_lane == 2'h1) ? {2'b11, tx_sr[31:30]} :
                         {3'b110, tx_sr[31]};
  wire [3:0] next_oe =
    (pin_lane == 2'h2) ? {4{drive}} :
    (pin_lane == 2'h1) ? {2'b11, {2{drive}}} : 4'b1101;

  // Receive assembly, MSB first
  wire [7:0] rx_cat = (lane_cur == 2'h2) ? {rx_sr[3:0], io_i[3:0]} :
                      (lane_cur == 2'h1) ? {rx_sr[5:0], io_i[1:0]} :
                                           {rx_sr[6:0], io_i[1]};
  wire [3:0] rx_sum = rx_bits + lane_n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  fci_tick_gen #(
    .DIV (SCLK_HALF_DIV)
  ) u_tick (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .run_i     ((state == fci_pkg::ST_SELECT) || (state == fci_pkg::ST_SHIFT) ||
                (state == fci_pkg::ST_DESELECT)),
    .tick_o    (tick)
  );

  fci_wait_timer #(
    .W (16)
  ) u_wait (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .start_i   ((state == fci_pkg::ST_DESELECT) && tick && need_wait),
    .len_i     (wait_len),
    .busy_o    (timer_busy),
    .done_o    (timer_done)
  );

  // ----------------------------------------------------------------
  // Frame control
  // ----------------------------------------------------------------
  // Select, serial clock and completion
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= fci_pkg::ST_IDLE;
      cs_n  <= 1'b1;
      sclk  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        fci_pkg::ST_IDLE: if (cmd_valid_i) begin
          state <= fci_pkg::ST_SELECT;
          cs_n  <= 1'b0;
        end
        fci_pkg::ST_SELECT: if (tick) begin
          state <= fci_pkg::ST_SHIFT;
        end
        fci_pkg::ST_SHIFT: if (tick) begin
          sclk <= !sclk;
          if (sclk && seg_last && next_seg == fci_pkg::SEG_END) begin
            state <= fci_pkg::ST_DESELECT;
            cs_n  <= 1'b1;
          end
        end
        fci_pkg::ST_DESELECT: if (tick) begin
          if (need_wait) begin
            state <= fci_pkg::ST_WAIT;
          end else begin
            state <= fci_pkg::ST_IDLE;
            done  <= 1'b1;
          end
        end
        fci_pkg::ST_WAIT: if (timer_done) begin
          state <= fci_pkg::ST_IDLE;
          done  <= 1'b1;
        end
        default: begin
          state <= fci_pkg::ST_IDLE;
          cs_n  <= 1'b1;
          sclk  <= 1'b0;
        end
      endcase
    end
  end

  // Segment, transmit shifter and clock count; shift on falling edges
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      seg      <= fci_pkg::SEG_END;
      tx_sr    <= 32'h00000000;
      clk_left <= 16'h0000;
      cmd_q    <= '0;
    end else if (state == fci_pkg::ST_IDLE && cmd_valid_i) begin
      cmd_q    <= cmd_i;
      seg      <= fci_pkg::SEG_OP;
      tx_sr    <= {fci_pkg::fci_opcode(cmd_i.kind), 24'h000000};
      clk_left <= fci_pkg::OP_CLKS;
    end else if (fall && seg_last) begin
      seg      <= next_seg;
      tx_sr    <= next_tx;
      clk_left <= next_clks;
    end else if (fall) begin
      tx_sr    <= tx_shift;
      clk_left <= clk_left - 16'h0001;
    end
  end

  // Receive on rising edges while reading
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || state == fci_pkg::ST_IDLE) begin
      rx_sr    <= 8'h00;
      rx_bits  <= 4'h0;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (rise && seg == fci_pkg::SEG_READ) begin
        rx_sr   <= rx_cat;
        rx_bits <= (rx_sum == 4'h8) ? 4'h0 : rx_sum;
        if (rx_sum == 4'h8) begin
          rx_data  <= rx_cat;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // Registered pin drive
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      io_o_q  <= 4'b1100;
      io_oe_q <= 4'b1101;
    end else begin
      io_o_q  <= next_io;
      io_oe_q <= next_oe;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_ready_o = (state == fci_pkg::ST_IDLE);
  assign done_o      = done;
  assign rx_o        = {rx_valid, rx_data};
  assign spi_o       = {sclk, cs_n, io_o_q, io_oe_q};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] wait_cyc;
  logic [7:0]  rise_cnt;

  // Cycles spent waiting, and rising edges in the frame
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wait_cyc <= 16'h0000;
      rise_cnt <= 8'h00;
    end else begin
      wait_cyc <= (state == fci_pkg::ST_WAIT) ? wait_cyc + 16'h0001 : 16'h0000;
      rise_cnt <= (state == fci_pkg::ST_IDLE) ? 8'h00 :
                  (rise && rise_cnt != 8'hff) ? rise_cnt + 8'h01 : rise_cnt;
    end
  end

  op_msb_first_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rise && seg == fci_pkg::SEG_OP && clk_left == fci_pkg::OP_CLKS)
      |-> io_o_q[0] == (fci_pkg::fci_opcode(cmd_q.kind) >= 8'h80))
    else $error("opcode msb not on io0 at first rising edge");

  cs_wait_high_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (state == fci_pkg::ST_WAIT) |-> cs_n && !sclk && timer_busy)
    else $error("select not held high during release wait");

  wait_length_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $fell(state == fci_pkg::ST_WAIT) |-> wait_cyc == wait_len && done_o)
    else $error("release wait length wrong");

  addr_zero_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(seg == fci_pkg::SEG_ADDR) |-> tx_sr[31:16] == 16'h0000 &&
      (is_param || tx_sr[15:8] == 8'h00))
    else $error("address upper bits not zero");

  mode_byte_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(seg == fci_pkg::SEG_MODE) |-> tx_sr[31:24] == 8'hff)
    else $error("continuous read mode byte not ff");

  quad_lanes_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rise && is_quad && seg == fci_pkg::SEG_ADDR) |-> io_oe_q == 4'hf)
    else $error("quad address not driven on four lanes");

  dual_turn_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rise && is_dual && seg == fci_pkg::SEG_READ) |-> io_oe_q[1:0] == 2'b00)
    else $error("dual read lanes still driven");

  table_start_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ($rose(seg == fci_pkg::SEG_READ) && (is_param || is_uid)) |-> rise_cnt == 8'h28)
    else $error("data phase not after fortieth clock");

  jedec_start_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ($rose(seg == fci_pkg::SEG_READ) && is_jedec) |-> rise_cnt == 8'h08)
    else $error("jedec read has address or dummy clocks");

  id_start_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ($rose(seg == fci_pkg::SEG_READ) && (is_devid || is_mfr)) |-> rise_cnt == 8'h20)
    else $error("id read data phase misplaced");

  idle_clock_low_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cs_n |-> !sclk ##1 (cs_n || !sclk))
    else $error("serial clock high while deselected");

endmodule
`default_nettype wire

/* verilog/fci_pkg.sv */
`default_nettype none
package fci_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS       = 40;
  localparam int unsigned RELEASE_WAIT_NS     = 3000;
  localparam int unsigned SIG_RELEASE_WAIT_NS = 3800;
  // Least times, rounded up to whole cycles
  localparam logic [15:0] RELEASE_WAIT_CYC =
    16'((RELEASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SIG_RELEASE_WAIT_CYC =
    16'((SIG_RELEASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned SCLK_HALF_DIV = 2;

  // ----------------------------------------------------------------
  // Opcodes and frame constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  OP_RELEASE       = 8'hab;
  localparam logic [7:0]  OP_MFR_ID        = 8'h90;
  localparam logic [7:0]  OP_MFR_ID_DUAL   = 8'h92;
  localparam logic [7:0]  OP_MFR_ID_QUAD   = 8'h94;
  localparam logic [7:0]  OP_UNIQUE_ID     = 8'h4b;
  localparam logic [7:0]  OP_JEDEC_ID      = 8'h9f;
  localparam logic [7:0]  OP_PARAM_TABLE   = 8'h5a;
  localparam logic [7:0]  MODE_BYTE_CONT   = 8'hff;
  localparam logic [15:0] OP_CLKS          = 16'h0008;
  localparam logic [15:0] ADDR_BITS        = 16'h0018;
  localparam logic [15:0] MODE_BITS        = 16'h0008;
  localparam logic [15:0] DEV_ID_DUMMY     = 16'h0018;
  localparam logic [15:0] UID_DUMMY        = 16'h0020;
  localparam logic [15:0] PARAM_DUMMY      = 16'h0008;
  localparam logic [15:0] QUAD_ID_DUMMY    = 16'h0004;
  localparam logic [15:0] PARAM_ADDR_HI    = 16'h0000;
  localparam logic [23:0] ID_ADDR          = 24'h000000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FCI_CMD_RELEASE     = 3'h0,
    FCI_CMD_DEVICE_ID   = 3'h1,
    FCI_CMD_MFR_ID      = 3'h2,
    FCI_CMD_MFR_ID_DUAL = 3'h3,
    FCI_CMD_MFR_ID_QUAD = 3'h4,
    FCI_CMD_UNIQUE_ID   = 3'h5,
    FCI_CMD_JEDEC_ID    = 3'h6,
    FCI_CMD_PARAM_TABLE = 3'h7
  } fci_kind_e;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_SELECT   = 5'h02,
    ST_SHIFT    = 5'h04,
    ST_DESELECT = 5'h08,
    ST_WAIT     = 5'h10
  } fci_state_e;

  typedef enum logic [5:0] {
    SEG_OP    = 6'h01,
    SEG_ADDR  = 6'h02,
    SEG_MODE  = 6'h04,
    SEG_DUMMY = 6'h08,
    SEG_READ  = 6'h10,
    SEG_END   = 6'h20
  } fci_seg_e;

  typedef struct packed {
    fci_kind_e  kind;
    logic [7:0] start_byte;
    logic [7:0] read_bytes;
  } fci_cmd_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fci_rx_s;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } fci_spi_s;

  // Opcode for a command kind
  function automatic logic [7:0] fci_opcode(input fci_kind_e k);
    fci_opcode = OP_RELEASE;
    unique case (k)
      FCI_CMD_RELEASE:     fci_opcode = OP_RELEASE;
      FCI_CMD_DEVICE_ID:   fci_opcode = OP_RELEASE;
      FCI_CMD_MFR_ID:      fci_opcode = OP_MFR_ID;
      FCI_CMD_MFR_ID_DUAL: fci_opcode = OP_MFR_ID_DUAL;
      FCI_CMD_MFR_ID_QUAD: fci_opcode = OP_MFR_ID_QUAD;
      FCI_CMD_UNIQUE_ID:   fci_opcode = OP_UNIQUE_ID;
      FCI_CMD_JEDEC_ID:    fci_opcode = OP_JEDEC_ID;
      FCI_CMD_PARAM_TABLE: fci_opcode = OP_PARAM_TABLE;
    endcase
  endfunction

endpackage
`default_nettype wire

/* verilog/fci_tick_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module fci_tick_gen #(
  parameter int unsigned DIV = 2
) (
  input  wire logic ref_clk_i,  // System clock
  input  wire logic srst_i,     // Sync reset, active high
  input  wire logic run_i,      // Count while high
  output logic      tick_o      // One-cycle enable pulse
);

  localparam logic [7:0] LAST = 8'(DIV - 1);

  logic [7:0] cnt;

  // Divider counter, restarts whenever idle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !run_i || cnt == LAST) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // Pulse at the end of each half period
  assign tick_o = run_i && (cnt == LAST);

endmodule
`default_nettype wire

/* verilog/fci_wait_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module fci_wait_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         ref_clk_i,  // System clock
  input  wire logic         srst_i,     // Sync reset, active high
  input  wire logic         start_i,    // Load and start
  input  wire logic [W-1:0] len_i,      // Cycles to wait, at least 1
  output logic              busy_o,     // Counting
  output logic              done_o      // Last cycle of the wait
);

  logic [W-1:0] cnt;

  // Down counter
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt <= '0;
    end else if (start_i) begin
      cnt <= len_i;
    end else if (cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

  assign busy_o = (cnt != '0);
  assign done_o = (cnt == W'(1));

endmodule
`default_nettype wire

/* tb/fci_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fci_dev_model #(
  parameter logic [7:0]  MFR_ID = 8'h3c,                // Arbitrary value
  parameter logic [7:0]  DEV_ID = 8'h13,                // Arbitrary value
  parameter logic [7:0]  MEM_TY = 8'h40,                // Memory type byte
  parameter logic [7:0]  CAP    = 8'h14,                // Capacity byte
  parameter logic [63:0] UID    = 64'h0123456789abcdef, // Unique number
  parameter real         REL_NS = 3000.0,               // Release wait
  parameter real         SIG_NS = 3800.0                // Signature release wait
) (
  input  wire logic       sclk_i,  // Serial clock
  input  wire logic       cs_n_i,  // Select, active low
  input  wire logic [3:0] io_i,    // Resolved io lines
  input  wire logic       busy_i,  // Erase or program running
  input  wire logic       pd_i,    // Rising edge enters power-down
  output logic      [3:0] io_o,    // Value put on io lines
  output int              viol_o   // Host faults seen
);
  // ------------------------------------------------------------
  // Frame decoder
  // ------------------------------------------------------------
  int          cnt, st, hb, ln, b;
  logic [7:0]  op, by;
  logic [31:0] hdr;
  logic        pd = 1'b0;
  logic        ign;
  realtime     t_rel = -1.0e9;
  realtime     w_rel = 0.0;
  initial viol_o = 0;
  initial io_o = 4'h0;
  // Stand-in for the separate power-down command
  always @(posedge pd_i) pd = 1'b1;
  // Frame start: select must have stayed high through the wait
  always @(negedge cs_n_i) begin
    if ($realtime - t_rel < w_rel) viol_o++;
    cnt = 0;
    hdr = '0;
    ign = busy_i;
  end
  // Opcode, address and mode bits sampled on rising edges
  always @(posedge sclk_i) if (!cs_n_i) begin
    if (cnt < 8) op = {op[6:0], io_i[0]};
    else if (cnt < hb) hdr = ln == 4 ? {hdr[27:0], io_i} :
                             ln == 2 ? {hdr[29:0], io_i[1:0]} : {hdr[30:0], io_i[0]};
    cnt++;
    if (cnt == 8) begin
      ln = op == 8'h92 ? 2 : op == 8'h94 ? 4 : 1;
      hb = op == 8'h94 ? 16 : op == 8'h92 ? 24 : 32;
      st = op == 8'h9f ? 8 : op == 8'h94 ? 20 : op == 8'h92 ? 24 :
           op inside {8'h4b, 8'h5a} ? 40 : 32;
      ign = ign || (pd && op != 8'hab);
    end
  end
  // Data out on falling edges, MSB first; an undriven lane toggles
  always @(negedge sclk_i) if (!cs_n_i) begin
    if (!ign && cnt >= 8 && cnt >= st) begin
      b = (cnt - st) * ln;
      case (op)
        8'hab: by = DEV_ID;
        8'h90, 8'h92, 8'h94: by = b[3] ? DEV_ID : MFR_ID;
        8'h4b: by = UID[63 - 8 * (b / 8 % 8) -: 8];
        8'h9f: by = b < 8 ? MFR_ID : b < 16 ? MEM_TY : CAP;
        default: by = (hdr[7:0] + 8'(b / 8)) ^ 8'ha5;
      endcase
      case (ln)
        1: io_o[1] = by[7 - b % 8];
        2: io_o[1:0] = by[7 - b % 8 -: 2];
        default: io_o = by[7 - b % 8 -: 4];
      endcase
    end else io_o = ~io_o;
  end
  // End of frame: release timing, address and mode byte checks
  always @(posedge cs_n_i) begin
    if (!ign && op == 8'hab && pd) begin
      pd = 1'b0;
      t_rel = $realtime;
      w_rel = cnt > 8 ? SIG_NS : REL_NS;
    end
    if (!ign && (op == 8'h90 && hdr[23:0] != 0 || op inside {8'h92, 8'h94} && hdr != 32'hff
        || op == 8'h5a && hdr[23:8] != 0)) viol_o++;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // Bench signals
  // ------------------------------------------------------------
  `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
  localparam logic [63:0] UID = 64'h0123456789abcdef;
  logic              ref_clk_i = 1'b0;
  logic              srst_i = 1'b1;
  logic              cmd_valid_i = 1'b0;
  logic              busy = 1'b0;
  logic              pd = 1'b0;
  logic              cmd_ready_o, done_o;
  fci_pkg::fci_cmd_s cmd_i = '0;
  fci_pkg::fci_rx_s  rx_o;
  fci_pkg::fci_spi_s spi_o;
  logic [3:0]        dev_io, io_i;
  logic [7:0]        got[$];
  int                viol, took, i, n_mismatch = 0, tests_run = 0, cyc = 0;
  // Each lane shows the controller where it drives, else the device
  assign io_i = (spi_o.io_oe & spi_o.io_out) | (~spi_o.io_oe & dev_io);
  fci_host_ctrl u_fci_host_ctrl (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .rx_o(rx_o),
    .done_o(done_o), .spi_o(spi_o), .io_i(io_i));
  fci_dev_model u_fci_dev_model (.sclk_i(spi_o.sclk), .cs_n_i(spi_o.cs_n), .io_i(io_i),
    .busy_i(busy), .pd_i(pd), .io_o(dev_io), .viol_o(viol));
  initial forever #20 ref_clk_i = ~ref_clk_i;
  // Cut a hang short
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One command: request, gather bytes until done, count cycles
  task automatic run(input fci_pkg::fci_kind_e k, input logic [7:0] sb, input logic [7:0] nb);
    got.delete();
    while (cmd_ready_o !== 1'b1) begin @(posedge ref_clk_i); #1; end
    cmd_i = '{k, sb, nb};
    cmd_valid_i = 1'b1;
    @(posedge ref_clk_i);
    #1 cmd_valid_i = 1'b0;
    `CHK(cmd_ready_o, 1'b0)
    for (took = 0; took < 5000 && done_o !== 1'b1; took++) begin
      @(posedge ref_clk_i);
      #1;
      if (rx_o.valid === 1'b1) got.push_back(rx_o.data);
    end
    `CHK(done_o, 1'b1)
    `CHK(got.size(), int'(nb))
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic sc_release;
    pd = 1'b1;
    run(fci_pkg::FCI_CMD_JEDEC_ID, 8'h00, 8'h01);
    `CHK(got[0] === 8'h3c, 1'b0)
    run(fci_pkg::FCI_CMD_RELEASE, 8'h00, 8'h00);
    `CHK(took >= int'(fci_pkg::RELEASE_WAIT_CYC), 1'b1)
    pd = 1'b0;
    run(fci_pkg::FCI_CMD_JEDEC_ID, 8'h00, 8'h03);
    `CHK({got[0], got[1], got[2]}, 24'h3c4014)
    `CHK(viol, 0)
  endtask
  task automatic sc_devid;
    pd = 1'b1;
    run(fci_pkg::FCI_CMD_DEVICE_ID, 8'h00, 8'h03);
    pd = 1'b0;
    for (i = 0; i < 3; i++) `CHK(got[i], 8'h13)
    `CHK(took >= int'(fci_pkg::SIG_RELEASE_WAIT_CYC), 1'b1)
    run(fci_pkg::FCI_CMD_UNIQUE_ID, 8'h00, 8'h08);
    for (i = 0; i < 8; i++) `CHK(got[i], UID[63 - 8 * i -: 8])
    `CHK(viol, 0)
  endtask
  task automatic sc_mfr_ids;
    for (int k = 2; k <= 4; k++) begin
      run(fci_pkg::fci_kind_e'(k), 8'h00, 8'h05);
      for (i = 0; i < 5; i++) `CHK(got[i], i % 2 ? 8'h13 : 8'h3c)
      `CHK(viol, 0)
    end
  endtask
  task automatic sc_param;
    run(fci_pkg::FCI_CMD_PARAM_TABLE, 8'hfe, 8'h03);
    for (i = 0; i < 3; i++) `CHK(got[i], (8'hfe + 8'(i)) ^ 8'ha5)
    `CHK(viol, 0)
  endtask
  task automatic sc_busy;
    busy = 1'b1;
    run(fci_pkg::FCI_CMD_DEVICE_ID, 8'h00, 8'h01);
    busy = 1'b0;
    `CHK(got[0] === 8'h13, 1'b0)
    run(fci_pkg::FCI_CMD_DEVICE_ID, 8'h00, 8'h01);
    `CHK(got[0], 8'h13)
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    #1 srst_i = 1'b0;
    sc_release();
    sc_devid();
    sc_mfr_ids();
    sc_param();
    sc_busy();
    final_report();
  end
endmodule
`default_nettype wire
